// >>> dv/ieflg_core_model.sv
// Purpose: behavioural core facing the interrupt logic
// Assumes: one pclk domain
// Notes: nested services each return ret_dly+1 clocks apart
`timescale 1ns/1ps
`default_nettype none
module ieflg_core_model (
   input  wire logic       pclk,               // clock
   input  wire logic       presetn,            // reset, low
   input  wire logic       slow,               // instr cycle every 4th clock
   input  wire logic [7:0] ret_dly,            // clocks to each return, less one
   input  wire logic       core_service_entry, // entry
   output logic            instr_boundary,     // instr cycle
   output logic            return_from_irq_instr_exec           // return
);
   logic [1:0] ph;
   logic [3:0] depth;
   logic [7:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph <= 2'h0;
         depth <= 4'h0;
         cnt <= 8'h0;
         instr_boundary <= 1'b0;
         return_from_irq_instr_exec <= 1'b0;
      end else begin
         ph <= ph + 2'h1;
         instr_boundary <= !slow || ph == 2'h3;
         return_from_irq_instr_exec <= 1'b0;
         if (core_service_entry) begin
            depth <= depth + 4'h1;
            cnt <= ret_dly;
         end else if (depth != 4'h0 && cnt == 8'h0) begin
            // innermost service returns first
            return_from_irq_instr_exec <= 1'b1;
            depth <= depth - 4'h1;
            cnt <= ret_dly;
         end else if (cnt != 8'h0) begin
            cnt <= cnt - 8'h1;
         end
      end
   end
endmodule // ieflg_core_model
`default_nettype wire

// >>> dv/ieflg_props.sv
// Purpose: port assertions of the interrupt logic
// Assumes: one pclk domain
// Notes: bound to ieflg_top
`timescale 1ns/1ps
`default_nettype none
module ieflg_props (
   input wire logic       pclk,               // clock
   input wire logic       presetn,            // reset, low
   input wire logic       instr_boundary,     // instr cycle
   input wire logic       return_from_irq_instr_exec,          // return
   input wire logic       core_force_call,    // forced call
   input wire logic [7:0] core_vector,        // vector
   input wire logic       core_service_entry, // entry
   input wire logic [1:0] core_service_level  // levels
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   call_six_long_a: assert property ($rose(core_force_call) |-> core_force_call[*6] ##1 !core_force_call)
      else $error("call length wrong");
   call_on_boundary_a: assert property ($rose(core_force_call) |-> $past(instr_boundary, 2))
      else $error("call without instruction cycle");
   entry_after_call_a: assert property ($fell(core_force_call) |-> core_service_entry)
      else $error("no entry after call");
   entry_has_call_a: assert property (core_service_entry |-> $past(core_force_call))
      else $error("entry without call");
   vector_held_a: assert property (core_force_call |-> $stable(core_vector))
      else $error("vector moved in call");
   entry_level_a: assert property (core_service_entry |-> core_service_level != 2'b00)
      else $error("entry without level");
   high_blocks_a: assert property (core_service_level[1] |-> !$rose(core_force_call))
      else $error("high service preempted");
   return_from_irq_instr_high_a: assert property (return_from_irq_instr_exec && core_service_level[1] |=> !core_service_level[1])
      else $error("return kept high level");
   return_from_irq_instr_low_a: assert property (return_from_irq_instr_exec && core_service_level == 2'b01 && !core_force_call
      |=> core_service_level == 2'b00)
      else $error("return kept low level");
endmodule // ieflg_props
bind ieflg_top ieflg_props u_props (.pclk(pclk), .presetn(presetn), .instr_boundary(instr_boundary),
   .return_from_irq_instr_exec(return_from_irq_instr_exec), .core_force_call(core_force_call), .core_vector(core_vector),
   .core_service_entry(core_service_entry), .core_service_level(core_service_level));
`default_nettype wire

// >>> dv/tb.sv
// Purpose: self-checking bench of the interrupt logic
// Assumes: apb master here, core model on the far side
// Notes: reset reads and register table first, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ieflg_pkg::*;
   typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] rd; logic err;} ieflg_row_s;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [9:0] paddr = 10'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, ib, return_from_irq_instr, fc, entry, irq;
   logic [4:0] evt = 5'h0;
   logic [5:0] ext = 6'h0;
   logic [7:0] vec, ret_dly = 8'h02;
   logic [1:0] lvl;
   int fails = 0, num_checks = 0, n;
   ieflg_row_s rows[11] = '{'{IDX_IEN3, 32'hff, 32'h3f, 1'b0}, '{IDX_IEN3, 32'h0, 32'h0, 1'b0},
      '{IDX_CIF, 32'hfc, 32'hfc, 1'b0}, '{IDX_CIF, 32'h0, 32'h0, 1'b0}, '{IDX_TSF, 32'h55, 32'h55, 1'b0},
      '{IDX_TSF, 32'h05, 32'h05, 1'b0}, '{IDX_MASK, 32'h7ff, 32'h7ff, 1'b0},
      '{IDX_MASK, 32'h0, 32'h0, 1'b0}, '{IDX_IENX, 32'hff, 32'h9f, 1'b0}, '{IDX_IENX, 32'h0, 32'h0, 1'b0},
      '{8'h55, 32'hff, 32'h0, 1'b1}};
   always #2 pclk = ~pclk;
   ieflg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .evt_serial_b_rx(evt[3]), .evt_converter_done(evt[1]), .evt_serial_a_rx(evt[2]),
      .evt_radio_fifo_err(evt[0]), .evt_cipher(evt[4]), .ext_pending(ext), .instr_boundary(ib),
      .return_from_irq_instr_exec(return_from_irq_instr), .core_force_call(fc), .core_vector(vec), .core_service_entry(entry),
      .core_service_level(lvl), .irq(irq));
   ieflg_core_model u_core (.pclk(pclk), .presetn(presetn), .slow(slow), .ret_dly(ret_dly),
      .core_service_entry(entry), .instr_boundary(ib), .return_from_irq_instr_exec(return_from_irq_instr));
   task automatic results();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(pready, 1'b1, "apb hang");
      if (pready !== 1'b1) results();
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp, "read");
   endtask
   task automatic pulse(input logic [4:0] m);
      @(posedge pclk);
      evt <= m;
      @(posedge pclk);
      evt <= 5'h0;
   endtask
   // bounded waits: a hang ends the run through results
   task automatic wait_entry(input logic [7:0] v);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (entry !== 1'b1 && n < 300);
      chk(entry, 1'b1, "no entry");
      chk(vec, v, "vector");
      if (entry !== 1'b1) results();
   endtask
   task automatic wait_idle();
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (lvl !== 2'b00 && n < 300);
      chk(lvl, 2'b00, "level");
      if (lvl !== 2'b00) results();
   endtask
   task automatic quiet(input int k);
      logic seen;
      seen = 1'b0;
      repeat (k) begin
         @(posedge pclk);
         if (fc !== 1'b0) seen = 1'b1;
      end
      chk(seen, 1'b0, "call while blocked");
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(IDX_TSF, TSF_RESET);
      rdchk(IDX_CIF, CIF_RESET);
      rdchk(IDX_IEN3, IEN3_RESET);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].idx, rows[i].wd);
         rdchk(rows[i].idx, rows[i].rd);
         chk(err, rows[i].err, "slverr");
      end
      apb(1'b1, IDX_IENX, 32'h1f);
      apb(1'b1, IDX_MASK, 32'h8);
      pulse(5'h0f);
      pulse(5'h10);
      quiet(20);
      rdchk(IDX_TSF, 32'haf);
      rdchk(IDX_CIF, 32'h03);
      rdchk(IDX_STAT, 32'h1f);
      chk(irq, 1'b1, "irq");
      apb(1'b1, IDX_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "irq masked");
      apb(1'b1, IDX_TSF, TSF_RESET);
      apb(1'b1, IDX_CIF, 32'h0);
      apb(1'b1, IDX_STAT, 32'h7ff);
      apb(1'b1, IDX_MASK, 32'h7ff);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "irq cleared");
      apb(1'b1, IDX_IENX, 32'h9f);
      apb(1'b1, IDX_IEN3, 32'h3f);
      for (int s = 0; s < NSRC; s++) begin
         if (s == SRC_ENC) continue;
         if (s < SRC_ENC) pulse(5'(1 << s));
         else ext <= 6'(1 << (s - SRC_P2));
         wait_entry(VEC_TABLE[s]);
         ext <= 6'h0;
         // flag edge, detect, six call cycles, entry seen one edge later
         if (s < SRC_ENC) chk(n, DETECT_CYCLES + CALL_CYCLES + 2, "latency");
         rdchk(IDX_TSF, TSF_RESET);
         wait_idle();
      end
      apb(1'b1, IDX_IEN3, 32'h3e);
      ext <= 6'h10;
      quiet(20);
      ext <= 6'h0;
      slow <= 1'b1;
      ret_dly <= 8'h28;
      for (int v = 1; v < 3; v++) begin
         apb(1'b1, IDX_CIF, 32'(v));
         wait_entry(VEC_TABLE[SRC_ENC]);
         apb(1'b1, IDX_CIF, 32'h0);
         wait_idle();
      end
      slow <= 1'b0;
      apb(1'b1, IDX_PRIO, 32'h8);
      pulse(5'h03);
      wait_entry(VEC_TABLE[SRC_RFERR]);
      pulse(5'h04);
      quiet(10);
      pulse(5'h08);
      wait_entry(VEC_TABLE[SRC_SB_RX]);
      chk(lvl, 2'b11, "nested level");
      wait_entry(VEC_TABLE[SRC_ADC]);
      wait_entry(VEC_TABLE[SRC_SA_RX]);
      wait_idle();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(IDX_PRIO, 32'h0);
      rdchk(IDX_TSF, TSF_RESET);
      results();
   end
endmodule // tb
`default_nettype wire

// >>> rtl/ieflg_pkg.sv
// Purpose: shared constants and types of the interrupt enable and flag logic
// Assumes: APB slave, 32-bit data, registers on word addresses index*4
// Notes:   one machine cycle is taken as one pclk cycle
package ieflg_pkg;
   localparam int          PADDR_W         = 10;
   // register indices; byte address is index*4
   localparam logic [7:0]  IDX_TSF         = 8'h88;
   localparam logic [7:0]  IDX_CIF         = 8'h98;
   localparam logic [7:0]  IDX_IEN3        = 8'h9a;
   localparam logic [7:0]  IDX_IENX        = 8'ha0;
   localparam logic [7:0]  IDX_PRIO        = 8'ha1;
   localparam logic [7:0]  IDX_STAT        = 8'ha2;
   localparam logic [7:0]  IDX_MASK        = 8'ha3;
   // timer_serial_irq_flags fields
   localparam int          TSF_SB_RX       = 7;
   localparam int          TSF_ADC         = 5;
   localparam int          TSF_SA_RX       = 3;
   localparam int          TSF_TRIG_HI     = 2;
   localparam int          TSF_RFERR       = 1;
   localparam int          TSF_TRIG_LO     = 0;
   localparam logic [7:0]  TSF_RESET       = 8'h05;
   localparam logic [7:0]  CIF_RESET       = 8'h00;
   // irq_enable_third fields
   localparam int          IEN3_WDT        = 5;
   localparam int          IEN3_P1         = 4;
   localparam int          IEN3_SB_TX      = 3;
   localparam int          IEN3_SA_TX      = 2;
   localparam int          IEN3_P2         = 1;
   localparam int          IEN3_RF         = 0;
   localparam logic [7:0]  IEN3_USED       = 8'h3f;
   localparam logic [7:0]  IEN3_RESET      = 8'h00;
   // extra enable register: global enable plus enables of locally held flags
   localparam int          IENX_GLOBAL     = 7;
   localparam int          IENX_ENC        = 4;
   localparam int          IENX_SB_RX      = 3;
   localparam int          IENX_SA_RX      = 2;
   localparam int          IENX_ADC        = 1;
   localparam int          IENX_RFERR      = 0;
   localparam logic [7:0]  IENX_USED       = 8'h9f;
   localparam logic [7:0]  IENX_RESET      = 8'h00;
   // sources in fixed arbitration order, lowest index wins within a level
   localparam int          NSRC            = 11;
   localparam int          SRC_RFERR       = 0;
   localparam int          SRC_ADC         = 1;
   localparam int          SRC_SA_RX       = 2;
   localparam int          SRC_SB_RX       = 3;
   localparam int          SRC_ENC         = 4;
   localparam int          SRC_P2          = 5;
   localparam int          SRC_SA_TX       = 6;
   localparam int          SRC_SB_TX       = 7;
   localparam int          SRC_P1          = 8;
   localparam int          SRC_RF          = 9;
   localparam int          SRC_WDT         = 10;
   localparam logic [NSRC-1:0][7:0] VEC_TABLE = {8'h8b, 8'h83, 8'h7b, 8'h73, 8'h3b, 8'h33,
                                                 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03};
   localparam logic [NSRC-1:0] SRC_RESET   = 11'h000;
   // response timing in machine cycles
   localparam int          DETECT_CYCLES   = 1;
   localparam int          CALL_CYCLES     = 6;
   localparam logic [2:0]  CALL_LAST       = 3'(CALL_CYCLES - 1);

   typedef enum logic [1:0] {
      IEFLG_IDLE   = 2'b00,
      IEFLG_DETECT = 2'b01,
      IEFLG_CALL   = 2'b10
   } ieflg_state_e;

   typedef struct packed {
      logic [7:0]      tsf;
      logic [7:0]      cif;
      logic [7:0]      ien3;
      logic [7:0]      ienx;
      logic [NSRC-1:0] prio;
      logic [NSRC-1:0] stat;
      logic [NSRC-1:0] mask;
      logic [NSRC-1:0] prev_req;
      logic [1:0]      in_svc;
      ieflg_state_e    state;
      logic [2:0]      cnt;
      logic [3:0]      sel;
      logic            sel_hi;
      logic [7:0]      vec;
      logic            entry;
      logic            irq;
      logic [31:0]     prdata;
      logic            pready;
      logic            pslverr;
   } ieflg_regs_s;
endpackage

// >>> rtl/ieflg_top.sv
// Purpose: interrupt enable and flag logic between peripheral sources and the core
// Assumes: event inputs are one-cycle pulses from logic on pclk; core inputs on pclk
// Notes:   two priority levels, fixed source order inside a level
// Notes on behaviour
// RULE1: third enable register bits 5..1 enable watchdog, port1, serial tx b/a, port2.
// RULE2: bit 0 enables radio general interrupt; bits 7:6 read zero.
// RULE3: an accepted interrupt presents that source's fixed vector address to the core.
// RULE4: a running service is preempted only by a strictly higher priority.
// RULE5: return-from-interrupt ends the service; core resumes its interrupted program.
// RULE6: flags set on their condition whatever the enable bits say.
// RULE7: enabled set flag is acknowledged next instruction cycle by forcing a long call.
// RULE8: requests at or below running priority wait until highest pending.
// RULE9: fastest response is one detect cycle plus six call cycles.
// RULE10: flag bit 7 set on serial b receive, cleared by hardware on vectoring.
// RULE11: flag bit 5 set on converter done, cleared by hardware on vectoring.
// RULE12: flag bit 3 set on serial a receive, cleared by hardware on vectoring.
// RULE13: flag bit 1 set on radio fifo error, cleared by hardware on vectoring.
// RULE14: software keeps trigger-type bits 2 and 0 at one; both reset to one.
// RULE15: flag bits 6 and 4 are unused and reset to zero.
// RULE16: two cipher flags; software setting either raises a cipher request.
// RULE17: cipher coprocessor event sets both flags; bits 7:2 unused, reset zero.
// RULE18: global enable zero blocks every acknowledge; one lets each enable decide.
// RULE19: equal-priority pending requests are chosen by fixed source order.
`timescale 1ns/1ps
`default_nettype none
module ieflg_top
   import ieflg_pkg::*;
(
   input  wire logic                           pclk,               // core clock
   input  wire logic                           presetn,            // async reset, active low
   input  wire logic                           psel,               // apb select
   input  wire logic                           penable,            // apb access phase
   input  wire logic                           pwrite,             // apb write
   input  wire logic [ieflg_pkg::PADDR_W-1:0]  paddr,              // apb byte address
   input  wire logic [31:0]                    pwdata,             // apb write data
   output logic      [31:0]                    prdata,             // apb read data
   output logic                                pready,             // apb ready
   output logic                                pslverr,            // apb error, unmapped
   input  wire logic                           evt_serial_b_rx,    // serial b receive pulse
   input  wire logic                           evt_converter_done, // converter done pulse
   input  wire logic                           evt_serial_a_rx,    // serial a receive pulse
   input  wire logic                           evt_radio_fifo_err, // radio fifo error pulse
   input  wire logic                           evt_cipher,         // cipher request pulse
   input  wire logic [5:0]                     ext_pending,        // flags held elsewhere
   input  wire logic                           instr_boundary,     // next instruction cycle
   input  wire logic                           return_from_irq_instr_exec,          // return-from-irq executed
   output logic                                core_force_call,    // long call forced
   output logic      [7:0]                     core_vector,        // vector address
   output logic                                core_service_entry, // call done pulse
   output logic      [1:0]                     core_service_level, // levels in service
   output logic                                irq                 // masked status level
);
   import ieflg_pkg::*;

   ieflg_regs_s      s;
   ieflg_regs_s      next_s;
   logic [NSRC-1:0]  req;
   logic [NSRC-1:0]  en;
   logic [NSRC-1:0]  elig_hi;
   logic [NSRC-1:0]  elig_lo;
   logic [3:0]       win_hi;
   logic [3:0]       win_lo;
   logic             found_hi;
   logic             found_lo;
   logic [1:0]       cur_level;
   logic             gate_on;
   logic             hi_open;
   logic             lo_open;

   logic             wr;
   logic             rd_setup;
   logic [7:0]       aidx;
   logic             amapped;
   logic [7:0]       wb;
   logic [NSRC-1:0]  wn;
   logic [31:0]      rdat;

   assign aidx = paddr[PADDR_W-1:2];
   assign wb   = pwdata[7:0];
   assign wn   = pwdata[NSRC-1:0];

   // pending view of every source, locally held flags plus external ones
   always_comb begin
      req            = '0;
      req[SRC_RFERR] = s.tsf[TSF_RFERR];
      req[SRC_ADC]   = s.tsf[TSF_ADC];
      req[SRC_SA_RX] = s.tsf[TSF_SA_RX];
      req[SRC_SB_RX] = s.tsf[TSF_SB_RX];
      req[SRC_ENC]   = |s.cif[1:0];                                // RULE16
      req[SRC_P2]    = ext_pending[0];
      req[SRC_SA_TX] = ext_pending[1];
      req[SRC_SB_TX] = ext_pending[2];
      req[SRC_P1]    = ext_pending[3];
      req[SRC_RF]    = ext_pending[4];
      req[SRC_WDT]   = ext_pending[5];
   end

   always_comb begin
      en            = '0;
      en[SRC_RFERR] = s.ienx[IENX_RFERR];
      en[SRC_ADC]   = s.ienx[IENX_ADC];
      en[SRC_SA_RX] = s.ienx[IENX_SA_RX];
      en[SRC_SB_RX] = s.ienx[IENX_SB_RX];
      en[SRC_ENC]   = s.ienx[IENX_ENC];
      en[SRC_P2]    = s.ien3[IEN3_P2];                             // RULE1
      en[SRC_SA_TX] = s.ien3[IEN3_SA_TX];                          // RULE1
      en[SRC_SB_TX] = s.ien3[IEN3_SB_TX];                          // RULE1
      en[SRC_P1]    = s.ien3[IEN3_P1];                             // RULE1
      en[SRC_WDT]   = s.ien3[IEN3_WDT];                            // RULE1
      en[SRC_RF]    = s.ien3[IEN3_RF];                             // RULE2
   end

   // current running level: 2 high, 1 low, 0 none
   always_comb begin
      if (s.in_svc[1]) begin
         cur_level = 2'd2;
      end else if (s.in_svc[0]) begin
         cur_level = 2'd1;
      end else begin
         cur_level = 2'd0;
      end
   end

   // only strictly higher levels than the running one are eligible;
   // an equal level waits, so a service never preempts its own peer
   assign gate_on = s.ienx[IENX_GLOBAL];                           // RULE18
   assign hi_open = (cur_level < 2'd2);                            // RULE4 RULE8
   assign lo_open = (cur_level < 2'd1);                            // RULE4 RULE8

   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         elig_hi[i] = req[i] && en[i] && gate_on && s.prio[i] && hi_open;   // RULE4 RULE8 RULE18
         elig_lo[i] = req[i] && en[i] && gate_on && !s.prio[i] && lo_open;  // RULE4 RULE8 RULE18
      end
   end

   // descending scan so the lowest index ends up chosen
   always_comb begin
      win_hi   = 4'h0;
      win_lo   = 4'h0;
      found_hi = 1'b0;
      found_lo = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (elig_hi[i]) begin
            win_hi   = 4'(i);                                      // RULE19
            found_hi = 1'b1;
         end
         if (elig_lo[i]) begin
            win_lo   = 4'(i);                                      // RULE19
            found_lo = 1'b1;
         end
      end
   end

   // register decode; read data prepared in the setup phase so it is a flop output
   always_comb begin
      amapped = 1'b1;
      rdat    = 32'h0000_0000;
      unique case (aidx)
         IDX_TSF: begin
            rdat[7:0] = s.tsf;
         end
         IDX_CIF: begin
            rdat[7:0] = s.cif;
         end
         IDX_IEN3: begin
            rdat[7:0] = s.ien3 & IEN3_USED;                        // RULE2
         end
         IDX_IENX: begin
            rdat[7:0] = s.ienx & IENX_USED;
         end
         IDX_PRIO: begin
            rdat[NSRC-1:0] = s.prio;
         end
         IDX_STAT: begin
            rdat[NSRC-1:0] = s.stat;
         end
         IDX_MASK: begin
            rdat[NSRC-1:0] = s.mask;
         end
         default: begin
            amapped = 1'b0;
         end
      endcase
   end

   assign rd_setup = psel && !penable;
   assign wr       = psel && penable && s.pready && pwrite && amapped;

   always_comb begin
      next_s = s;

      // apb handshake: one access cycle, no waits
      next_s.pready  = rd_setup;
      next_s.pslverr = rd_setup && !amapped;
      if (rd_setup) begin
         next_s.prdata = rdat;
      end

      // software writes
      if (wr) begin
         unique case (aidx)
            IDX_TSF: begin
               next_s.tsf = wb;                                    // RULE14 RULE15
            end
            IDX_CIF: begin
               next_s.cif = wb;                                    // RULE16 RULE17
            end
            IDX_IEN3: begin
               next_s.ien3 = wb & IEN3_USED;                       // RULE1 RULE2
            end
            IDX_IENX: begin
               next_s.ienx = wb & IENX_USED;                       // RULE18
            end
            IDX_PRIO: begin
               next_s.prio = wn;
            end
            IDX_STAT: begin
               // write one to clear; a set in the same cycle is applied after
               next_s.stat = s.stat & ~wn;
            end
            IDX_MASK: begin
               next_s.mask = wn;
            end
            default: begin
               next_s.tsf = s.tsf;
            end
         endcase
      end

      // vectoring sequence
      next_s.entry = 1'b0;
      unique case (s.state)
         IEFLG_IDLE: begin
            if (instr_boundary && (found_hi || found_lo)) begin
               next_s.state  = IEFLG_DETECT;                       // RULE7
               next_s.sel_hi = found_hi;
               // a high request beats every low one found in the same cycle
               if (found_hi) begin
                  next_s.sel = win_hi;                             // RULE19
                  next_s.vec = VEC_TABLE[win_hi];                  // RULE3
               end else begin
                  next_s.sel = win_lo;                             // RULE19
                  next_s.vec = VEC_TABLE[win_lo];                  // RULE3
               end
            end
         end
         IEFLG_DETECT: begin
            next_s.state = IEFLG_CALL;                             // RULE9
            next_s.cnt   = 3'd0;
            // the four flags held in tsf drop as the core vectors
            unique case (int'(s.sel))
               SRC_SB_RX: begin
                  next_s.tsf[TSF_SB_RX] = 1'b0;                    // RULE10
               end
               SRC_ADC: begin
                  next_s.tsf[TSF_ADC] = 1'b0;                      // RULE11
               end
               SRC_SA_RX: begin
                  next_s.tsf[TSF_SA_RX] = 1'b0;                    // RULE12
               end
               SRC_RFERR: begin
                  next_s.tsf[TSF_RFERR] = 1'b0;                    // RULE13
               end
               // cipher and external flags belong to their owners
               default: begin
                  next_s.tsf = next_s.tsf;
               end
            endcase
         end
         IEFLG_CALL: begin
            if (s.cnt == CALL_LAST) begin
               next_s.state = IEFLG_IDLE;                          // RULE9
               next_s.entry = 1'b1;
               if (s.sel_hi) begin
                  next_s.in_svc[1] = 1'b1;                         // RULE4
               end else begin
                  next_s.in_svc[0] = 1'b1;                         // RULE4
               end
            end else begin
               next_s.cnt = s.cnt + 3'd1;                          // RULE9
            end
         end
         default: next_s.state = IEFLG_IDLE;
      endcase

      // return ends the innermost service; the core restores its own program counter
      if (return_from_irq_instr_exec) begin
         if (s.in_svc[1]) begin
            next_s.in_svc[1] = 1'b0;                               // RULE5
         end else begin
            next_s.in_svc[0] = 1'b0;                               // RULE5
         end
      end

      // hardware sets come last so an event beats a clear in the same cycle
      if (evt_serial_b_rx) begin
         next_s.tsf[TSF_SB_RX] = 1'b1;                             // RULE6 RULE10
      end
      if (evt_converter_done) begin
         next_s.tsf[TSF_ADC] = 1'b1;                               // RULE6 RULE11
      end
      if (evt_serial_a_rx) begin
         next_s.tsf[TSF_SA_RX] = 1'b1;                             // RULE6 RULE12
      end
      if (evt_radio_fifo_err) begin
         next_s.tsf[TSF_RFERR] = 1'b1;                             // RULE6 RULE13
      end
      if (evt_cipher) begin
         next_s.cif[1:0] = 2'b11;                                  // RULE6 RULE17
      end

      // sticky status of newly pending sources, set beats the write-one clear
      next_s.prev_req = req;
      next_s.stat     = next_s.stat | (req & ~s.prev_req);
      next_s.irq      = |(next_s.stat & next_s.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s          <= '0;
         s.tsf      <= TSF_RESET;                                  // RULE14 RULE15
         s.cif      <= CIF_RESET;                                  // RULE17
         s.ien3     <= IEN3_RESET;                                 // RULE2
         s.ienx     <= IENX_RESET;
         s.prio     <= SRC_RESET;
         s.stat     <= SRC_RESET;
         s.mask     <= SRC_RESET;
         s.prev_req <= SRC_RESET;
         s.state    <= IEFLG_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign prdata             = s.prdata;
   assign pready             = s.pready;
   assign pslverr            = s.pslverr;
   // the call state is the only code with bit 1 set, so this is a plain flop bit
   assign core_force_call    = s.state[1];
   assign core_vector        = s.vec;
   assign core_service_entry = s.entry;
   assign core_service_level = s.in_svc;
   assign irq                = s.irq;
endmodule // ieflg_top
`default_nettype wire
